// file: src/fdh_pkg.sv
// fdh_pkg: constants, types and timing for the floppy controller host port
// assumes a single 50 MHz clock domain
`default_nettype none
package fdh_pkg;
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned STEP_PULSE_NS  = 1000;
   localparam int unsigned STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STEP_RATE_US   = 3000;
   localparam int unsigned STEP_RATE_CYC  = STEP_RATE_US * CLK_MHZ;
   localparam int unsigned STACK_DEPTH    = 9;
   localparam logic [4:0] OP_SPECIFY   = 5'h03;
   localparam logic [4:0] OP_WRITE     = 5'h05;
   localparam logic [4:0] OP_READ      = 5'h06;
   localparam logic [4:0] OP_RECAL     = 5'h07;
   localparam logic [4:0] OP_SENSE_INT = 5'h08;
   localparam logic [4:0] OP_SEEK      = 5'h0F;
   localparam logic [3:0] LEN_RW      = 4'h9;
   localparam logic [3:0] LEN_SEEK    = 4'h3;
   localparam logic [3:0] LEN_RECAL   = 4'h2;
   localparam logic [3:0] LEN_SPECIFY = 4'h3;
   localparam logic [3:0] LEN_ONE     = 4'h1;
   localparam logic [2:0] RES_RW      = 3'h7;
   localparam logic [2:0] RES_SENSE   = 3'h2;
   localparam logic [2:0] RES_ONE     = 3'h1;
   localparam int unsigned MS_BUSY = 4;
   localparam int unsigned MS_NDM  = 5;
   localparam int unsigned MS_DIO  = 6;
   localparam int unsigned MS_RQM  = 7;
   localparam int unsigned CMD_MFM_BIT = 6;
   localparam int unsigned SPEC_ND_BIT = 0;
   localparam logic [7:0] ST_INVALID    = 8'h80;
   localparam logic [7:0] ST0_SEEK_END  = 8'h20;
   localparam logic [7:0] ST0_ABNORMAL  = 8'h40;
   localparam logic [7:0] ST1_NOT_WRIT  = 8'h02;
   localparam logic [7:0] LCT_CYL       = 8'h2B;
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RESULT} fdh_phase_e;
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic register_select;
   } fdh_host_s;
   typedef struct packed {
      logic rw_seek;
      logic low_current_or_direction;
      logic fault_reset_or_step;
      logic double_density_select;
      logic vco_sync;
   } fdh_drv_s;
endpackage
`default_nettype wire

// file: src/fdh_data_stack.sv
// fdh_data_stack: byte stack behind the data register port
// assumes writes and reads are indexed by the command sequencer
`default_nettype none
module fdh_data_stack #(
   parameter int unsigned DEPTH = 9
) (
   input  wire logic                     sys_clk_i,
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
   input  wire logic [7:0]               wr_data_i,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
   output logic      [7:0]               rd_data_o
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge sys_clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_idx_i] <= wr_data_i;
      end
   end

   assign rd_data_o = mem[rd_idx_i];
endmodule
`default_nettype wire

// file: src/fdh_step_pulser.sv
// fdh_step_pulser: one head step pulse followed by the step-rate gap
// assumes start_i is only pulsed while busy_o is low
`default_nettype none
module fdh_step_pulser #(
   parameter int unsigned PULSE_CYC = 50,
   parameter int unsigned GAP_CYC   = 150000
) (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic start_i,
   output logic      pulse_o,
   output logic      busy_o
);
   localparam int unsigned CW = $clog2(PULSE_CYC + GAP_CYC + 1);
   localparam logic [CW-1:0] TOTAL = CW'(PULSE_CYC + GAP_CYC);
   localparam logic [CW-1:0] PULSE = CW'(PULSE_CYC);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   always_comb
   begin
      cnt_d = cnt_q;
      if (start_i)
      begin
         cnt_d = TOTAL;
      end
      else if (cnt_q != '0)
      begin
         cnt_d = cnt_q - CW'(1);
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   assign pulse_o = (cnt_q > TOTAL - PULSE);
   assign busy_o  = (cnt_q != '0);
endmodule
`default_nettype wire

// file: src/fdh_host_port.sv
// fdh_host_port: processor port, dma handshake and drive control pins
// assumes all inputs synchronous to sys_clk_i; disk byte stream is external
// Operation
// R1: select low, read low, write high: main status drives data bus
// R2: select high: read gives data register byte, write loads it
// R3: main status is read-only and readable in every phase
// R4: data register is an 8-bit stack, one entry on the bus at once
// R5: status bits 0..3 set while drive 0..3 is seeking
// R6: status bit 4 shows a command in progress
// R7: status bit 5 set only in non-dma execution phase
// R8: status bit 6 is direction, 1 means controller to processor
// R9: status bit 7 shows data register ready for a byte
// R10: non-dma mode interrupts for every data byte transferred
// R11: dma mode moves execution bytes under dma controller control
// R12: reset makes controller idle and drive outputs low
// R13: strobes act only with chip select low; bus off otherwise
// R14: dma request high asks transfer; acknowledge low marks the cycle
// R15: terminal count high ends the dma transfer
// R16: rw/seek pin high in seek mode, low in read/write mode
// R17: shared pin is low current in read/write, direction in seek
// R18: shared pin is fault reset in read/write, step in seek
// R19: shared input is write protect in read/write, two-side in seek
// R20: shared input is fault in read/write, track zero in seek
// R21: density output 1 for double, 0 for single density
// R22: vco sync low inhibits the loop oscillator, high enables it
// R23: processor checks bits 6 and 7 before each command or result byte
// R24: dma request drops as soon as acknowledge goes low
// R25: terminal count end raises interrupt; first result read clears it
// R26: illegal select and strobe combinations change no register
`default_nettype none
module fdh_host_port #(
   parameter int unsigned STEP_RATE_CYC = fdh_pkg::STEP_RATE_CYC
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   input  wire fdh_pkg::fdh_host_s host_i,
   input  wire logic [7:0]        data_i,
   output logic      [7:0]        data_o,
   output logic                   data_oe_o,
   output logic                   dma_request_o,
   input  wire logic              dma_acknowledge_n_i,
   input  wire logic              terminal_count_i,
   output logic                   interrupt_o,
   output fdh_pkg::fdh_drv_s      drv_o,
   input  wire logic              write_protect_or_two_side_i,
   input  wire logic              fault_or_track_zero_i,
   input  wire logic [7:0]        disk_rd_byte_i,
   input  wire logic              disk_rd_valid_i,
   output logic      [7:0]        disk_wr_byte_o,
   output logic                   disk_wr_valid_o
);
   localparam int unsigned IW = $clog2(fdh_pkg::STACK_DEPTH);
   fdh_pkg::fdh_phase_e phase_q, phase_d;
   logic [4:0] op_q, op_d;
   logic [3:0] cnt_q, cnt_d;
   logic [2:0] res_idx_q, res_idx_d, res_len_q, res_len_d;
   logic [7:0] byte_q, byte_d, st0_q, st0_d, st1_q, st1_d;
   logic [7:0] dout_q, dout_d, tgt_q, tgt_d, wr_byte_q, wr_byte_d;
   logic [7:0] cyl_q [4];
   logic [7:0] cyl_d [4];
   logic [3:0] seek_q, seek_d;
   logic [1:0] sdrv_q, sdrv_d, sense_drv_q, sense_drv_d;
   logic nondma_q, nondma_d, mfm_q, mfm_d, wrdir_q, wrdir_d, pend_q, pend_d;
   logic int_q, int_d, drq_q, drq_d, doe_q, doe_d, wr_vld_q, wr_vld_d;
   logic rd_seen_q, wr_seen_q, recal_q, recal_d, sense_q, sense_d;
   logic dir_q, dir_d, fr_q, fr_d, step_start, step_start_q;
   fdh_pkg::fdh_drv_s drv_q, drv_d;
   logic rd_lvl, wr_lvl, rd_edge, wr_edge, dsel, status_rd, data_rd, data_wr;
   logic [3:0] len;
   logic [7:0] status, res_byte, stk_byte;
   logic [IW-1:0] stk_rd_idx;
   logic step_pulse, step_busy, seeking;

   // only the two documented strobe patterns count
   assign rd_lvl    = !host_i.cs_n && !host_i.rd_n && host_i.wr_n; // R13 R26
   assign wr_lvl    = !host_i.cs_n && host_i.rd_n && !host_i.wr_n; // R13 R26
   assign rd_edge   = rd_lvl && !rd_seen_q;
   assign wr_edge   = wr_lvl && !wr_seen_q;
   // acknowledge selects the data register during a dma cycle
   assign dsel      = host_i.register_select || !dma_acknowledge_n_i; // R11
   assign status_rd = rd_edge && !dsel; // R1 R3
   assign data_rd   = rd_edge && dsel; // R2
   assign data_wr   = wr_edge && dsel; // R2 R26
   assign seeking   = |seek_q;

   always_comb
   begin
      status          = {4'h0, seek_q}; // R5
      status[fdh_pkg::MS_BUSY] = (phase_q != fdh_pkg::PH_CMD) || (cnt_q != 4'h0); // R6
      status[fdh_pkg::MS_NDM]  = (phase_q == fdh_pkg::PH_EXEC) && nondma_q; // R7
      status[fdh_pkg::MS_DIO]  = (phase_q == fdh_pkg::PH_RESULT) ||
                                 ((phase_q == fdh_pkg::PH_EXEC) && !wrdir_q); // R8
      status[fdh_pkg::MS_RQM]  = (phase_q != fdh_pkg::PH_EXEC) || pend_q; // R9 R23
   end

   always_comb
   begin
      len = fdh_pkg::LEN_ONE;
      case (cnt_q == 4'h0 ? data_i[4:0] : op_q)
         fdh_pkg::OP_READ, fdh_pkg::OP_WRITE: len = fdh_pkg::LEN_RW;
         fdh_pkg::OP_SEEK:    len = fdh_pkg::LEN_SEEK;
         fdh_pkg::OP_RECAL:   len = fdh_pkg::LEN_RECAL;
         fdh_pkg::OP_SPECIFY: len = fdh_pkg::LEN_SPECIFY;
         default:             len = fdh_pkg::LEN_ONE;
      endcase
   end

   assign stk_rd_idx = IW'(res_idx_q - 3'h1);
   always_comb
   begin
      case (res_idx_q)
         3'h0:    res_byte = st0_q;
         3'h1:    res_byte = st1_q;
         3'h2:    res_byte = fdh_pkg::RESET_BYTE;
         default: res_byte = stk_byte;
      endcase
   end

   fdh_data_stack #(
      .DEPTH     (fdh_pkg::STACK_DEPTH)
   ) u_stack (
      .sys_clk_i (sys_clk_i),
      .wr_en_i   (data_wr && phase_q == fdh_pkg::PH_CMD), // R4
      .wr_idx_i  (IW'(cnt_q)),
      .wr_data_i (data_i),
      .rd_idx_i  (stk_rd_idx),
      .rd_data_o (stk_byte)
   );

   fdh_step_pulser #(
      .PULSE_CYC (fdh_pkg::STEP_PULSE_CYC),
      .GAP_CYC   (STEP_RATE_CYC)
   ) u_step (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .start_i   (step_start),
      .pulse_o   (step_pulse),
      .busy_o    (step_busy)
   );

   always_comb
   begin
      phase_d = phase_q;  op_d = op_q;  cnt_d = cnt_q;
      res_idx_d = res_idx_q;  res_len_d = res_len_q;  byte_d = byte_q;
      st0_d = st0_q;  st1_d = st1_q;  tgt_d = tgt_q;  seek_d = seek_q;
      sdrv_d = sdrv_q;  sense_drv_d = sense_drv_q;  sense_d = sense_q;
      nondma_d = nondma_q;  mfm_d = mfm_q;  wrdir_d = wrdir_q;
      pend_d = pend_q;  int_d = int_q;  drq_d = drq_q;  recal_d = recal_q;
      dir_d = dir_q;  fr_d = 1'b0;  wr_vld_d = 1'b0;  wr_byte_d = wr_byte_q;
      step_start = 1'b0;
      cyl_d = cyl_q;
      dout_d = dout_q;
      if (status_rd)
      begin
         dout_d = status; // R1 R3
      end
      doe_d = rd_lvl; // R13
      case (phase_q)
         fdh_pkg::PH_CMD:
         begin
            if (data_wr)
            begin
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == 4'h0)
               begin
                  op_d = data_i[4:0];
                  mfm_d = data_i[fdh_pkg::CMD_MFM_BIT]; // R21
                  if (data_i[4:0] == fdh_pkg::OP_SENSE_INT)
                  begin
                     int_d = 1'b0;
                  end
               end
               if (cnt_q + 4'h1 == len)
               begin
                  cnt_d = 4'h0;
                  case (cnt_q == 4'h0 ? data_i[4:0] : op_q)
                     fdh_pkg::OP_READ, fdh_pkg::OP_WRITE:
                     begin
                        wrdir_d = (op_q == fdh_pkg::OP_WRITE);
                        fr_d = fault_or_track_zero_i; // R18 R20
                        if (op_q == fdh_pkg::OP_WRITE && write_protect_or_two_side_i) // R19
                        begin
                           st0_d = fdh_pkg::ST0_ABNORMAL;
                           st1_d = fdh_pkg::ST1_NOT_WRIT;
                           phase_d = fdh_pkg::PH_RESULT;
                           res_len_d = fdh_pkg::RES_RW;
                           res_idx_d = 3'h0;
                           int_d = 1'b1;
                        end
                        else
                        begin
                           st0_d = fault_or_track_zero_i ? fdh_pkg::ST0_ABNORMAL
                                                         : fdh_pkg::RESET_BYTE;
                           st1_d = fdh_pkg::RESET_BYTE;
                           phase_d = fdh_pkg::PH_EXEC;
                        end
                     end
                     fdh_pkg::OP_SEEK, fdh_pkg::OP_RECAL:
                     begin
                        if (!seeking)
                        begin
                           sdrv_d = (op_q == fdh_pkg::OP_SEEK) ? sdrv_q : data_i[1:0];
                           seek_d[(op_q == fdh_pkg::OP_SEEK) ? sdrv_q : data_i[1:0]] = 1'b1; // R5
                           recal_d = (op_q == fdh_pkg::OP_RECAL);
                           tgt_d = (op_q == fdh_pkg::OP_SEEK) ? data_i : 8'h00;
                        end
                     end
                     fdh_pkg::OP_SPECIFY:
                     begin
                        nondma_d = data_i[fdh_pkg::SPEC_ND_BIT];
                     end
                     fdh_pkg::OP_SENSE_INT:
                     begin
                        st0_d = sense_q ? (fdh_pkg::ST0_SEEK_END | {6'h00, sense_drv_q})
                                        : fdh_pkg::ST_INVALID;
                        st1_d = cyl_q[sense_drv_q];
                        res_len_d = sense_q ? fdh_pkg::RES_SENSE : fdh_pkg::RES_ONE;
                        sense_d = 1'b0;
                        res_idx_d = 3'h0;
                        phase_d = fdh_pkg::PH_RESULT;
                     end
                     default:
                     begin
                        st0_d = fdh_pkg::ST_INVALID;
                        res_len_d = fdh_pkg::RES_ONE;
                        res_idx_d = 3'h0;
                        phase_d = fdh_pkg::PH_RESULT;
                     end
                  endcase
               end
               else if (cnt_q == 4'h1 && !seeking)
               begin
                  sdrv_d = data_i[1:0];
               end
            end
         end
         fdh_pkg::PH_EXEC:
         begin
            if (!wrdir_q && disk_rd_valid_i && !pend_q)
            begin
               byte_d = disk_rd_byte_i;
               pend_d = 1'b1;
               int_d = nondma_q; // R10
               drq_d = !nondma_q; // R14
            end
            if (wrdir_q && !pend_q && !wr_vld_q)
            begin
               pend_d = 1'b1;
               int_d = nondma_q; // R10
               drq_d = !nondma_q; // R14
            end
            if (data_rd && !wrdir_q && pend_q)
            begin
               dout_d = byte_q;
               pend_d = 1'b0;
               int_d = 1'b0;
            end
            if (data_wr && wrdir_q && pend_q)
            begin
               wr_byte_d = data_i;
               wr_vld_d = 1'b1;
               pend_d = 1'b0;
               int_d = 1'b0;
            end
            if (!dma_acknowledge_n_i)
            begin
               drq_d = 1'b0; // R24
            end
            if (terminal_count_i)
            begin
               phase_d = fdh_pkg::PH_RESULT; // R15
               res_idx_d = 3'h0;
               res_len_d = fdh_pkg::RES_RW;
               pend_d = 1'b0;
               drq_d = 1'b0;
               int_d = 1'b1; // R25
            end
         end
         fdh_pkg::PH_RESULT:
         begin
            if (data_rd)
            begin
               dout_d = res_byte;
               if (res_idx_q == 3'h0)
               begin
                  int_d = 1'b0; // R25
               end
               res_idx_d = res_idx_q + 3'h1;
               if (res_idx_q + 3'h1 == res_len_q)
               begin
                  phase_d = fdh_pkg::PH_CMD;
               end
            end
         end
         default:
         begin
            phase_d = fdh_pkg::PH_CMD;
         end
      endcase
      // seek engine: one step per pulser period until target or track zero
      if (seeking && !step_busy && !step_start_q)
      begin
         if (recal_q ? fault_or_track_zero_i : (cyl_q[sdrv_q] == tgt_q)) // R20
         begin
            seek_d[sdrv_q] = 1'b0;
            cyl_d[sdrv_q] = recal_q ? 8'h00 : cyl_q[sdrv_q];
            sense_d = 1'b1;
            sense_drv_d = sdrv_q;
            int_d = 1'b1;
         end
         else
         begin
            step_start = 1'b1;
            dir_d = !recal_q && (tgt_q > cyl_q[sdrv_q]);
            cyl_d[sdrv_q] = (!recal_q && tgt_q > cyl_q[sdrv_q]) ? cyl_q[sdrv_q] + 8'h01
                                                                : cyl_q[sdrv_q] - 8'h01;
         end
      end
      drv_d.rw_seek = seeking; // R16
      drv_d.low_current_or_direction = seeking ? dir_q
                                               : (cyl_q[sdrv_q] >= fdh_pkg::LCT_CYL); // R17
      drv_d.fault_reset_or_step = seeking ? step_pulse : fr_q; // R18
      drv_d.double_density_select = mfm_q; // R21
      drv_d.vco_sync = (phase_q == fdh_pkg::PH_EXEC) && !wrdir_q; // R22
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         phase_q <= fdh_pkg::PH_CMD; // R12
         op_q <= '0;  cnt_q <= '0;  res_idx_q <= '0;  res_len_q <= '0;
         byte_q <= '0;  st0_q <= '0;  st1_q <= '0;  dout_q <= '0;
         tgt_q <= '0;  wr_byte_q <= '0;  seek_q <= '0;  sdrv_q <= '0;
         sense_drv_q <= '0;  nondma_q <= 1'b0;  mfm_q <= 1'b0;  wrdir_q <= 1'b0;
         pend_q <= 1'b0;  int_q <= 1'b0;  drq_q <= 1'b0;  doe_q <= 1'b0;
         wr_vld_q <= 1'b0;  rd_seen_q <= 1'b0;  wr_seen_q <= 1'b0;
         recal_q <= 1'b0;  sense_q <= 1'b0;  dir_q <= 1'b0;  fr_q <= 1'b0;
         step_start_q <= 1'b0;
         drv_q <= '0; // R12
         for (int i = 0; i < 4; i++)
         begin
            cyl_q[i] <= '0;
         end
      end
      else
      begin
         phase_q <= phase_d;  op_q <= op_d;  cnt_q <= cnt_d;
         res_idx_q <= res_idx_d;  res_len_q <= res_len_d;  byte_q <= byte_d;
         st0_q <= st0_d;  st1_q <= st1_d;  dout_q <= dout_d;  tgt_q <= tgt_d;
         wr_byte_q <= wr_byte_d;  seek_q <= seek_d;  sdrv_q <= sdrv_d;
         sense_drv_q <= sense_drv_d;  nondma_q <= nondma_d;  mfm_q <= mfm_d;
         wrdir_q <= wrdir_d;  pend_q <= pend_d;  int_q <= int_d;  drq_q <= drq_d;
         doe_q <= doe_d;  wr_vld_q <= wr_vld_d;  rd_seen_q <= rd_lvl;
         wr_seen_q <= wr_lvl;  recal_q <= recal_d;  sense_q <= sense_d;
         dir_q <= dir_d;  fr_q <= fr_d;  step_start_q <= step_start;
         drv_q <= drv_d;  cyl_q <= cyl_d;
      end
   end

   assign data_o          = dout_q;
   assign data_oe_o       = doe_q;
   assign dma_request_o   = drq_q;
   assign interrupt_o     = int_q;
   assign drv_o           = drv_q;
   assign disk_wr_byte_o  = wr_byte_q;
   assign disk_wr_valid_o = wr_vld_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   a_status_read_bus: assert property (status_rd |=> data_o == $past(status)) // R1
      else $error("status read did not present main status");
   a_oe_needs_cs: assert property (data_oe_o |-> $past(!host_i.cs_n)) // R13
      else $error("data bus enabled without chip select");
   a_drq_drop_dma_acknowledge_n: assert property (drq_q && !dma_acknowledge_n_i |=> !dma_request_o) // R24
      else $error("dma request held after acknowledge");
   a_tc_ends_exec: assert property (phase_q == fdh_pkg::PH_EXEC && terminal_count_i
                                    |=> phase_q == fdh_pkg::PH_RESULT && interrupt_o) // R15
      else $error("terminal count did not start result phase");
   a_first_result_clr: assert property (phase_q == fdh_pkg::PH_RESULT && res_idx_q == 3'h0
                                        && data_rd |=> !interrupt_o) // R25
      else $error("first result read left interrupt set");
   a_ndm_exec_only: assert property (status[fdh_pkg::MS_NDM]
                                     |-> phase_q == fdh_pkg::PH_EXEC && nondma_q) // R7
      else $error("non-dma bit outside execution");
   a_dio_cmd_zero: assert property (phase_q == fdh_pkg::PH_CMD |-> !status[fdh_pkg::MS_DIO]) // R8
      else $error("direction bit set in command phase");
   a_seek_pin_mode: assert property ($rose(seeking) |=> drv_o.rw_seek) // R16
      else $error("seek start did not raise rw/seek pin");
   a_illegal_noeff: assert property (!host_i.rd_n && !host_i.wr_n && !terminal_count_i
                                     |=> $stable(cnt_q) && $stable(phase_q)) // R26
      else $error("illegal strobe pair changed state");
   a_nondma_int: assert property (phase_q == fdh_pkg::PH_EXEC && nondma_q && !wrdir_q
                                  && disk_rd_valid_i && !pend_q && !terminal_count_i
                                  |=> interrupt_o ##0 status[fdh_pkg::MS_RQM]) // R10
      else $error("non-dma byte without interrupt");

   c_cmd_byte: cover property (data_wr && phase_q == fdh_pkg::PH_CMD);
   c_tc_result: cover property (phase_q == fdh_pkg::PH_EXEC && terminal_count_i);
   c_seek_done: cover property ($fell(seeking));
   c_dma_cycle: cover property (drq_q ##1 !dma_acknowledge_n_i);
endmodule
`default_nettype wire

// file: sim/fdh_drive_model.sv
// fdh_drive_model: one floppy drive as seen from the host port pins
// assumes drive outputs of fdh_host_port and the same clock
`default_nettype none
module fdh_drive_model (
   input  wire logic              sys_clk_i,
   input  wire fdh_pkg::fdh_drv_s drv_i,
   input  wire logic              protect_i,
   output logic                   write_protect_or_two_side_o,
   output logic                   fault_or_track_zero_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int   cyl = 3;
   logic step_q = 1'b0;
   // head starts off track zero; each step moves it one cylinder outward
   always @(posedge sys_clk_i)
   begin
      step_q <= drv_i.fault_reset_or_step;
      if (drv_i.rw_seek && drv_i.fault_reset_or_step && !step_q && cyl > 0)
         cyl <= cyl - 1;
   end
   assign write_protect_or_two_side_o    = drv_i.rw_seek ? 1'b0 : protect_i;
   assign fault_or_track_zero_o = drv_i.rw_seek ? (cyl == 0) : 1'b0;
endmodule
`default_nettype wire

// file: sim/test_floppy_ctrl_host_interface.sv
// test_floppy_ctrl_host_interface: self-checking bench for the host port
// assumes fdh_pkg compiled first; dma acknowledge and terminal count driven by the bench, drive model attached
`default_nettype none
module test_floppy_ctrl_host_interface;
   timeunit 1ns;
   timeprecision 1ns;
   logic              sys_clk = 1'b0;
   logic              reset = 1'b1;
   fdh_pkg::fdh_host_s host = '1;
   fdh_pkg::fdh_host_s bad[4] = '{4'h1, 4'h0, 4'h4, 4'hB};
   fdh_pkg::fdh_drv_s drv;
   logic [7:0]        din = 8'h00;
   logic [7:0]        dout, rd, oe_s;
   logic [7:0]        cmd[9];
   logic [7:0]        exp_q[$];
   logic              oe, irq, protect = 1'b0, wp, trk;
   logic              dma_request, dma_acknowledge_n = 1'b1, tc = 1'b0, rv = 1'b0;
   int                num_errors = 0;
   int                tests_run = 0;
   int                cyc = 0;
   always #10 sys_clk = ~sys_clk;
   fdh_host_port #(.STEP_RATE_CYC(20)) fdh_host_port_inst (
      .sys_clk_i(sys_clk), .reset_i(reset), .host_i(host), .data_i(din),
      .data_o(dout), .data_oe_o(oe), .dma_request_o(dma_request), .dma_acknowledge_n_i(dma_acknowledge_n),
      .terminal_count_i(tc), .interrupt_o(irq), .drv_o(drv),
      .write_protect_or_two_side_i(wp), .fault_or_track_zero_i(trk),
      .disk_rd_byte_i(cmd[8]), .disk_rd_valid_i(rv), .disk_wr_byte_o(), .disk_wr_valid_o());
   fdh_drive_model fdh_drive_model_inst (
      .sys_clk_i(sys_clk), .drv_i(drv), .protect_i(protect),
      .write_protect_or_two_side_o(wp), .fault_or_track_zero_o(trk));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic sel, input logic wr, input logic [7:0] d);
      @(negedge sys_clk);
      host = '{cs_n: 1'b0, rd_n: wr, wr_n: !wr, register_select: sel};
      din = d;
      repeat (2) @(negedge sys_clk);
      rd = dout;
      oe_s = {7'h00, oe};
      host = '1;
      @(negedge sys_clk);
   endtask
   task automatic stat(input logic [7:0] exp, input logic [7:0] m);
      int n;
      n = 0;
      acc(1'b0, 1'b0, 8'h00);
      while (rd[7] !== 1'b1 && n < 500)
      begin
         acc(1'b0, 1'b0, 8'h00);
         n++;
      end
      chk("status_oe", 8'h01, oe_s);
      chk("status", exp, rd & m);
   endtask
   task automatic put(input logic [7:0] b);
      stat(8'h80, 8'hC0);
      acc(1'b1, 1'b1, b);
   endtask
   task automatic drain();
      while (exp_q.size() > 0)
      begin
         stat(8'hC0, 8'hC0);
         acc(1'b1, 1'b0, 8'h00);
         chk("result", exp_q.pop_front(), rd);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         num_errors++;
         conclude();
      end
   end
   initial
   begin
      void'($urandom(32'h19AB3777));
      repeat (6) @(negedge sys_clk);
      chk("drv_reset", 8'h00, {3'h0, drv});
      reset = 1'b0;
      foreach (bad[i])
      begin
         @(negedge sys_clk);
         host = bad[i];
         din = {3'h0, fdh_pkg::OP_SENSE_INT};
         repeat (2) @(negedge sys_clk);
         if (bad[i].cs_n)
            chk("oe_off", 8'h00, {7'h00, oe});
         host = '1;
      end
      stat(8'h80, 8'hFF);
      protect = 1'b1;
      cmd[0] = {3'h2, fdh_pkg::OP_WRITE};
      foreach (cmd[i])
         if (i > 0)
            cmd[i] = (i == 1) ? 8'h00 : 8'($urandom);
      foreach (cmd[i])
         put(cmd[i]);
      stat(8'hD0, 8'hF0);
      exp_q = '{fdh_pkg::ST0_ABNORMAL, fdh_pkg::ST1_NOT_WRIT, 8'h00,
                cmd[2], cmd[3], cmd[4], cmd[5]};
      drain();
      protect = 1'b0;
      foreach (bad[i])
      begin
         put(i == 0 ? {3'h0, fdh_pkg::OP_SENSE_INT} : 8'h1F - 8'(i));
         exp_q = '{fdh_pkg::ST_INVALID};
         drain();
      end
      put({3'h0, fdh_pkg::OP_RECAL});
      put(8'h00);
      repeat (4) @(negedge sys_clk);
      acc(1'b0, 1'b0, 8'h00);
      chk("seeking", 8'h01, rd & 8'h01);
      chk("rw_seek", 8'h01, {7'h00, drv.rw_seek});
      for (int n = 0; n < 2000 && irq !== 1'b1; n++)
         @(negedge sys_clk);
      put({3'h0, fdh_pkg::OP_SENSE_INT});
      exp_q = '{fdh_pkg::ST0_SEEK_END, 8'h00};
      drain();
      stat(8'h80, 8'hC1);
      // dma read: one disk byte, acknowledge cycle, terminal count
      cmd[0] = {3'h2, fdh_pkg::OP_READ};
      foreach (cmd[i])
         put(cmd[i]);
      chk("vco_mfm", 8'h03, {6'h00, drv.vco_sync, drv.double_density_select});
      rv = 1'b1;
      @(negedge sys_clk);
      rv = 1'b0;
      dma_acknowledge_n = 1'b0;
      chk("drq", 8'h01, {7'h00, dma_request});
      acc(1'b0, 1'b0, 8'h00);
      chk("dma_byte", cmd[8], rd);
      chk("drq_ack", 8'h00, {7'h00, dma_request});
      dma_acknowledge_n = 1'b1;
      tc = 1'b1;
      @(negedge sys_clk);
      tc = 1'b0;
      chk("tc_irq", 8'h01, {7'h00, irq});
      exp_q = '{8'h00, 8'h00, 8'h00, cmd[2], cmd[3], cmd[4], cmd[5]};
      drain();
      chk("irq_clr", 8'h00, {7'h00, irq});
      conclude();
   end
endmodule
`default_nettype wire
